/* File: pkg/sdr_params.svh */
// sdr_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the sdram device core, 50 MHz system clock
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SDR_REG_CONFIG 32'h0000_0000
`define SDR_REG_STATUS 32'h0000_0004
`define SDR_REG_REFCNT 32'h0000_0008
`define SDR_REG_SRCNT 32'h0000_000c
// ----------------------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------------------
`define SDR_CFG_CL_LSB 0
`define SDR_CFG_BL_LSB 2
`define SDR_CL_RESET 2'h3
`define SDR_BL_RESET 3'h3
`define SDR_BL_FULL 3'h7
// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define SDR_ST_OPEN_LSB 0
`define SDR_ST_SELFREF 4
`define SDR_ST_RDBUSY 5
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SDR_CLK_PS 20000
`define SDR_REFI_PS 15625000
// longest interval: round down
`define SDR_REFI_CYC ((`SDR_REFI_PS) / (`SDR_CLK_PS))
`define SDR_RESP_OKAY 2'h0
`define SDR_RESP_DECERR 2'h3
`endif

/* File: pkg/sdr_pkg.sv */
// sdr_pkg: types shared by the sdram device core
// assumes: fixed 16-bit data path, four banks
`default_nettype none
package sdr_pkg;
  // pins sampled on every rising edge
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [1:0] dqm;
  } sdr_pins_t;
  typedef enum logic [3:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF,
    CMD_LMR} sdr_cmd_t;
  typedef enum logic [1:0] {MD_NORMAL, MD_SELFREF} sdr_mode_t;
  // one column fetch in flight toward the data pins
  typedef struct packed {
    logic v;
    logic [1:0] ba;
    logic [11:0] row;
    logic [9:0] col;
  } sdr_ent_t;
  typedef struct packed {
    sdr_mode_t mode;
    logic [3:0] bank_open;
    logic [3:0][11:0] bank_row;
    logic [11:0] ref_cnt;
    logic [9:0] sr_tmr;
    logic [31:0] sr_refs;
    logic [1:0] cl;
    logic [2:0] bl;
    logic rd_on;
    logic [1:0] rd_ba;
    logic [11:0] rd_row;
    logic [9:0] rd_base;
    logic [9:0] rd_cnt;
    sdr_ent_t [2:0] pipe;
    logic [1:0] dqm_q;
    logic [1:0] oe;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdr_state_t;
endpackage : sdr_pkg
`default_nettype wire

/* File: hdl/sdr_core.sv */
// sdr_core: four-bank sdram device core (refresh, activate, read bursts)
// assumes: pins synchronous to aclk, controller keeps its own timing limits
//
// Summary of operation
// - refresh row from internal counter, 4096 per 64ms
// - refresh with cke low enters self refresh
// - self refresh runs on internal timer
// - activates to other banks allowed, gap apart
// - first word after read latency, then each clock
// - burst end floats pins, full page wraps
// - reads accepted every clock, any bank
// - mask two clocks ahead, write floats pins
// - refresh encoding: cke high auto, low self
// - precharge bit selects one or all banks
`include "sdr_params.svh"
`default_nettype none
module sdr_core #(
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter int REFI_CYC = `SDR_REFI_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire sdr_pkg::sdr_pins_t pins,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [1:0] dq_oe
);
  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (COL_W < 8 || COL_W > 10 || ROW_W < 1 || ROW_W > 12 || REFI_CYC < 2 || REFI_CYC > 1023)
  begin : g_bad_param
    $error("sdr_core: unsupported geometry or refresh interval");
  end

  localparam int DEPTH = 4 << (ROW_W + COL_W);
  localparam int AW = ROW_W + COL_W + 2;

  sdr_pkg::sdr_state_t s_q, s_d;
  sdr_pkg::sdr_cmd_t cmd;
  sdr_pkg::sdr_ent_t sel;
  logic [15:0] mem [0:DEPTH-1];
  logic [15:0] rdata_q;
  logic wr_en;
  logic [AW-1:0] widx;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // command decode, also used by the checks
  function automatic sdr_pkg::sdr_cmd_t sdr_decode(input sdr_pkg::sdr_pins_t p);
    logic [2:0] c;
    c = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) return sdr_pkg::CMD_NOP;
    case (c)
      3'h3: return sdr_pkg::CMD_ACT;
      3'h5: return sdr_pkg::CMD_RD;
      3'h4: return sdr_pkg::CMD_WR;
      3'h6: return sdr_pkg::CMD_BST;
      3'h2: return sdr_pkg::CMD_PRE;
      3'h1: return sdr_pkg::CMD_REF;
      3'h0: return sdr_pkg::CMD_LMR;
      default: return sdr_pkg::CMD_NOP;
    endcase
  endfunction

  // address match for the register map
  function automatic logic sdr_hit(input logic [31:0] a, input logic [31:0] off);
    return a[31:2] == off[31:2];
  endfunction

  // column of beat cnt, wrapping inside the burst or the page
  function automatic logic [9:0] sdr_col(input logic [9:0] base, input logic [9:0] cnt,
                                         input logic [2:0] bl);
    logic [9:0] mask;
    logic [9:0] sum;
    sum = base + cnt;
    if (bl == `SDR_BL_FULL) mask = 10'((11'h1 << COL_W) - 11'h1);
    else mask = (10'h1 << bl) - 10'h1;
    return (base & ~mask) | (sum & mask);
  endfunction

  function automatic logic [AW-1:0] sdr_idx(input logic [1:0] ba, input logic [11:0] row,
                                            input logic [9:0] col);
    return {ba, row[ROW_W-1:0], col[COL_W-1:0]};
  endfunction

  assign cmd = sdr_decode(pins);
  // output stage picks the fetch due at the read latency
  assign sel = (s_q.cl == 2'h3) ? s_q.pipe[1] : s_q.pipe[0];
  assign wr_en = (s_q.mode == sdr_pkg::MD_NORMAL) && pins.cke && (cmd == sdr_pkg::CMD_WR);
  assign widx = sdr_idx(pins.ba, s_q.bank_row[pins.ba], pins.addr[9:0]);

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // read pipeline advances every clock
    s_d.pipe[0] = '0;
    s_d.pipe[1] = s_q.pipe[0];
    s_d.pipe[2] = s_q.pipe[1];
    s_d.dqm_q = pins.dqm;
    // burst generator feeds one column per clock
    if (s_q.rd_on) begin
      s_d.pipe[0] = '{v: 1'b1, ba: s_q.rd_ba, row: s_q.rd_row,
                      col: sdr_col(s_q.rd_base, s_q.rd_cnt, s_q.bl)};
      s_d.rd_cnt = s_q.rd_cnt + 10'h1;
      if (s_q.bl != `SDR_BL_FULL && s_q.rd_cnt == (10'h1 << s_q.bl) - 10'h1) begin
        s_d.rd_on = 1'b0;
      end
    end
    // command handling per mode
    case (s_q.mode)
      sdr_pkg::MD_NORMAL: begin
        if (pins.cke) begin
          case (cmd)
            sdr_pkg::CMD_ACT: begin
              s_d.bank_open[pins.ba] = 1'b1;
              s_d.bank_row[pins.ba] = pins.addr;
            end
            sdr_pkg::CMD_RD: begin
              // new read truncates any running burst
              s_d.pipe[0] = '{v: 1'b1, ba: pins.ba, row: s_q.bank_row[pins.ba],
                              col: pins.addr[9:0]};
              s_d.rd_on = (s_q.bl != 3'h0);
              s_d.rd_ba = pins.ba;
              s_d.rd_row = s_q.bank_row[pins.ba];
              s_d.rd_base = pins.addr[9:0];
              s_d.rd_cnt = 10'h1;
            end
            sdr_pkg::CMD_WR: begin
              // write ends the read and floats the pins
              s_d.rd_on = 1'b0;
              s_d.pipe = '0;
            end
            // stop the generator, drop this edge's fetch too
            sdr_pkg::CMD_BST: begin
              s_d.rd_on = 1'b0;
              s_d.pipe[0] = '0;
            end
            sdr_pkg::CMD_PRE: begin
              if (pins.addr[10]) begin
                s_d.bank_open = 4'h0;
                s_d.rd_on = 1'b0;
                s_d.pipe[0] = '0;
              end else begin
                s_d.bank_open[pins.ba] = 1'b0;
                if (pins.ba == s_q.rd_ba) begin
                  s_d.rd_on = 1'b0;
                  s_d.pipe[0] = '0;
                end
              end
            end
            // address ignored, internal row counter advances
            sdr_pkg::CMD_REF: s_d.ref_cnt = s_q.ref_cnt + 12'h1;
            default: ;
          endcase
        end else if (cmd == sdr_pkg::CMD_REF) begin
          // refresh with cke low enters self refresh
          s_d.mode = sdr_pkg::MD_SELFREF;
          s_d.sr_tmr = 10'(REFI_CYC);
          s_d.rd_on = 1'b0;
        end
      end
      sdr_pkg::MD_SELFREF: begin
        // all pins but cke ignored here
        if (pins.cke) begin
          s_d.mode = sdr_pkg::MD_NORMAL;
        end else if (s_q.sr_tmr == 10'h0) begin
          // internal timer drives the refreshes
          s_d.ref_cnt = s_q.ref_cnt + 12'h1;
          s_d.sr_refs = s_q.sr_refs + 32'h1;
          s_d.sr_tmr = 10'(REFI_CYC);
        end else begin
          s_d.sr_tmr = s_q.sr_tmr - 10'h1;
        end
      end
      default: s_d.mode = sdr_pkg::MD_NORMAL;
    endcase
    // data pins follow the pipeline, masked by dqm two clocks earlier
    s_d.oe = sel.v ? ~s_q.dqm_q : 2'h0;
    if (wr_en) s_d.oe = 2'h0;
    // register bus: write address and data in either order
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `SDR_RESP_OKAY;
      if (sdr_hit(s_q.awaddr, `SDR_REG_CONFIG)) begin
        if (s_q.wstrb[0]) begin
          // only latencies 2 and 3, lengths 1..8 and full page stick
          if (s_q.wdata[`SDR_CFG_CL_LSB +: 2] >= 2'h2) begin
            s_d.cl = s_q.wdata[`SDR_CFG_CL_LSB +: 2];
          end
          if (s_q.wdata[`SDR_CFG_BL_LSB +: 3] <= 3'h3 ||
              s_q.wdata[`SDR_CFG_BL_LSB +: 3] == `SDR_BL_FULL) begin
            s_d.bl = s_q.wdata[`SDR_CFG_BL_LSB +: 3];
          end
        end
      end else if (!sdr_hit(s_q.awaddr, `SDR_REG_STATUS) &&
                   !sdr_hit(s_q.awaddr, `SDR_REG_REFCNT) &&
                   !sdr_hit(s_q.awaddr, `SDR_REG_SRCNT)) begin
        s_d.bresp = `SDR_RESP_DECERR;
      end
    end
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `SDR_RESP_OKAY;
      s_d.rdata = 32'h0;
      if (sdr_hit(araddr, `SDR_REG_CONFIG)) begin
        s_d.rdata[`SDR_CFG_CL_LSB +: 2] = s_q.cl;
        s_d.rdata[`SDR_CFG_BL_LSB +: 3] = s_q.bl;
      end else if (sdr_hit(araddr, `SDR_REG_STATUS)) begin
        s_d.rdata[`SDR_ST_OPEN_LSB +: 4] = s_q.bank_open;
        s_d.rdata[`SDR_ST_SELFREF] = (s_q.mode == sdr_pkg::MD_SELFREF);
        s_d.rdata[`SDR_ST_RDBUSY] = s_q.rd_on | s_q.pipe[0].v | s_q.pipe[1].v;
      end else if (sdr_hit(araddr, `SDR_REG_REFCNT)) begin
        s_d.rdata[11:0] = s_q.ref_cnt;
      end else if (sdr_hit(araddr, `SDR_REG_SRCNT)) begin
        s_d.rdata = s_q.sr_refs;
      end else begin
        s_d.rresp = `SDR_RESP_DECERR;
      end
    end
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= sdr_pkg::MD_NORMAL;
      s_q.cl <= `SDR_CL_RESET;
      s_q.bl <= `SDR_BL_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // array write (byte mask, no latency) and read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 16'h0;
    end else if (clk_en) begin
      if (wr_en && !pins.dqm[0]) mem[widx][7:0] <= dq_i[7:0];
      if (wr_en && !pins.dqm[1]) mem[widx][15:8] <= dq_i[15:8];
      rdata_q <= mem[sdr_idx(sel.ba, sel.row, sel.col)];
    end
  end

  assign awready = !s_q.aw_got && !s_q.bvalid;
  assign wready = !s_q.w_got && !s_q.bvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign dq_o = rdata_q;
  assign dq_oe = s_q.oe;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  logic normal;
  assign normal = (s_q.mode == sdr_pkg::MD_NORMAL);

  sequence s_rd_cl2;
    normal && pins.cke && cmd == sdr_pkg::CMD_RD && s_q.cl == 2'h2 && pins.dqm == 2'h0
    ##1 !wr_en;
  endsequence
  sequence s_rd_cl3;
    normal && pins.cke && cmd == sdr_pkg::CMD_RD && s_q.cl == 2'h3
    ##1 pins.dqm == 2'h0 && !wr_en ##1 !wr_en;
  endsequence
  sequence s_rd_bl1;
    normal && pins.cke && cmd == sdr_pkg::CMD_RD && s_q.cl == 2'h2 && s_q.bl == 3'h0
    ##1 cmd == sdr_pkg::CMD_NOP [*2];
  endsequence

  property p_ref_counts;
    normal && pins.cke && cmd == sdr_pkg::CMD_REF |=> s_q.ref_cnt == $past(s_q.ref_cnt) + 12'h1;
  endproperty
  a_ref_counts: assert property (p_ref_counts) else $error("auto refresh missed count");
  property p_sr_entry;
    normal && !pins.cke && cmd == sdr_pkg::CMD_REF |=> s_q.mode == sdr_pkg::MD_SELFREF;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");
  property p_sr_ignore;
    s_q.mode == sdr_pkg::MD_SELFREF && !pins.cke |=> $stable(s_q.bank_open) && !s_q.rd_on;
  endproperty
  a_sr_ignore: assert property (p_sr_ignore) else $error("input taken in self refresh");
  property p_sr_internal;
    s_q.mode == sdr_pkg::MD_SELFREF && !pins.cke && s_q.sr_tmr == 10'h0
    |=> s_q.ref_cnt == $past(s_q.ref_cnt) + 12'h1 && s_q.sr_tmr == 10'(REFI_CYC);
  endproperty
  a_sr_internal: assert property (p_sr_internal) else $error("self refresh tick lost");
  property p_act_open;
    normal && pins.cke && cmd == sdr_pkg::CMD_ACT |=> s_q.bank_open[$past(pins.ba)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank");
  property p_lat2;
    s_rd_cl2 |=> dq_oe == 2'h3;
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency 2 word missing");
  property p_lat3;
    s_rd_cl3 |=> dq_oe == 2'h3;
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency 3 word missing");
  property p_burst_end;
    s_rd_bl1 |=> dq_oe == 2'h0;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("pins not released");
  property p_rd_each;
    normal && pins.cke && cmd == sdr_pkg::CMD_RD
    |=> s_q.pipe[0].v && s_q.pipe[0].col == $past(pins.addr[9:0]);
  endproperty
  a_rd_each: assert property (p_rd_each) else $error("read not taken");
  property p_wr_float;
    wr_en |=> dq_oe == 2'h0 && !s_q.rd_on;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("pins driven after write");
  property p_pre_all;
    normal && pins.cke && cmd == sdr_pkg::CMD_PRE && pins.addr[10] |=> s_q.bank_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all failed");
endmodule : sdr_core
`default_nettype wire

/* File: test/sdr_ctl_model.sv */
// sdr_ctl_model: controller side that drives the sdram command pins
// assumes: tasks are called just after a rising aclk edge
`default_nettype none
module sdr_ctl_model #(
  parameter int CLK_NS = 20,
  parameter int RCD_NS = 20,
  parameter int XSR_CYC = 4
) (
  input wire logic aclk,
  output var sdr_pkg::sdr_pins_t pins,
  output var logic [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // command issue
  // ----------
  // column delay in whole clocks, rounded up
  localparam int RCD_CYC = (RCD_NS + CLK_NS - 1) / CLK_NS;
  logic cke_q;
  initial begin
    cke_q = 1'b1;
    pins = {1'b1, 4'h7, 16'h0};
    dq_i = 16'h0;
  end
  // one command per call, left on the pins until the next call
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a,
                     input logic [15:0] d, input logic [1:0] m);
    @(posedge aclk);
    pins <= {cke_q, c, ba, a, m};
    // data only with a write, a moving pattern otherwise
    dq_i <= (c == 4'h4) ? d : ~dq_i;
  endtask
  // open a row, then idle out the column delay
  task automatic act(input logic [1:0] ba, input logic [11:0] row);
    cmd(4'h3, ba, row, 16'h0, 2'h0);
    repeat (RCD_CYC) cmd(4'h7, 2'h0, 12'h0, 16'h0, 2'h0);
  endtask
  // refresh encoding with clock enable low, kept low after
  task automatic sr_enter;
    cke_q = 1'b0;
    cmd(4'h1, 2'h0, 12'h0, 16'h0, 2'h0);
  endtask
  // clock is already running; raise clock enable, then nops only
  task automatic sr_exit;
    cke_q = 1'b1;
    repeat (XSR_CYC) cmd(4'h7, 2'h0, 12'h0, 16'h0, 2'h0);
  endtask
endmodule // sdr_ctl_model
`default_nettype wire

/* File: test/sdr_core_tb.sv */
// sdr_core_tb: self-checking bench for the sdram device core
// assumes: sdr_ctl_model drives the pins, one 50 MHz clock
`include "sdr_params.svh"
`default_nettype none
module sdr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] c_nop = 4'h7;
  localparam logic [3:0] c_rd = 4'h5;
  localparam logic [3:0] c_wr = 4'h4;
  localparam logic [3:0] c_bst = 4'h6;
  localparam logic [3:0] c_pre = 4'h2;
  localparam logic [3:0] c_ref = 4'h1;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, dq_oe;
  logic [31:0] rdata;
  logic [15:0] dq_i, dq_o;
  sdr_pkg::sdr_pins_t pins;
  logic [15:0] mem [0:255];
  logic [17:0] exp_q [0:11];
  logic [17:0] obs [$];
  logic [31:0] seed = 32'h7fb3;
  int fails = 0;
  int checks = 0;
  always #10 aclk = ~aclk;
  // capture the data pins once each edge has settled
  always @(negedge aclk) obs.push_back({dq_oe, dq_o});
  sdr_core #(.ROW_W(2), .COL_W(8), .REFI_CYC(8)) u_sdr_core (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pins(pins), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  sdr_ctl_model u_sdr_ctl_model (.aclk(aclk), .pins(pins), .dq_i(dq_i));
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // a used-up wait counts as a mismatch and ends the run
  task automatic hang(input int n);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    hang(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    hang(n);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic cm(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m);
    u_sdr_ctl_model.cmd(c, 2'h0, a, 16'h0, m);
  endtask
  task automatic nops(input int n);
    repeat (n) cm(c_nop, 12'h0, 2'h0);
  endtask
  // start a window: index 1 is the edge of the next command
  task automatic go;
    obs.delete();
    foreach (exp_q[i]) exp_q[i] = 18'h0;
  endtask
  task automatic ew(input int i, input int c);
    exp_q[i] = {2'b11, mem[c]};
  endtask
  task automatic cmp_rd;
    for (int i = 0; i < 12; i++) begin
      chk({30'h0, obs[i][17:16]}, {30'h0, exp_q[i][17:16]});
      if (exp_q[i][16]) chk({16'h0, obs[i][15:0]}, {16'h0, exp_q[i][15:0]});
    end
  endtask
  // ----------
  // main sequence, read latency 2 so a read at index 1 shows at 3
  // ----------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`SDR_REG_CONFIG, 32'h0000_000f, `SDR_RESP_OKAY);
    axr(32'h0000_0040, 32'h0, `SDR_RESP_DECERR);
    axw(32'h0000_0040, 32'h1, `SDR_RESP_DECERR);
    axw(`SDR_REG_STATUS, 32'hffff_ffff, `SDR_RESP_OKAY);
    axw(`SDR_REG_CONFIG, 32'h0000_000a, `SDR_RESP_OKAY);
    axr(`SDR_REG_CONFIG, 32'h0000_000a, `SDR_RESP_OKAY);
    u_sdr_ctl_model.act(2'h0, 12'h1);
    u_sdr_ctl_model.act(2'h1, 12'h2);
    axr(`SDR_REG_STATUS, 32'h0000_0003, `SDR_RESP_OKAY);
    // fill columns 0..7 and the last column of the page
    for (int c = 0; c < 9; c++) begin
      seed = lfsr(seed);
      mem[(c == 8) ? 255 : c] = seed[15:0];
      u_sdr_ctl_model.cmd(c_wr, 2'h0, (c == 8) ? 12'hff : 12'(c), seed[15:0], 2'h0);
    end
    go();
    cm(c_rd, 12'h0, 2'h0);
    cm(c_rd, 12'h4, 2'h0);
    nops(12);
    ew(3, 0);
    for (int k = 4; k < 8; k++) ew(k, k);
    cmp_rd();
    go();
    cm(c_rd, 12'h0, 2'h0);
    cm(c_nop, 12'h0, 2'h0);
    cm(c_bst, 12'h0, 2'h0);
    nops(12);
    ew(3, 0);
    ew(4, 1);
    cmp_rd();
    // mask two words, then a write cuts the read short
    go();
    cm(c_rd, 12'h0, 2'h0);
    cm(c_nop, 12'h0, 2'h3);
    cm(c_nop, 12'h0, 2'h3);
    seed = lfsr(seed);
    mem[7] = seed[15:0];
    u_sdr_ctl_model.cmd(c_wr, 2'h0, 12'h7, seed[15:0], 2'h0);
    nops(12);
    ew(3, 0);
    cmp_rd();
    go();
    cm(c_rd, 12'h4, 2'h0);
    cm(c_nop, 12'h0, 2'h0);
    cm(c_pre, 12'h0, 2'h0);
    nops(12);
    ew(3, 4);
    ew(4, 5);
    cmp_rd();
    axr(`SDR_REG_STATUS, 32'h0000_0002, `SDR_RESP_OKAY);
    u_sdr_ctl_model.act(2'h0, 12'h1);
    go();
    cm(c_rd, 12'h5, 2'h0);
    nops(12);
    ew(3, 5);
    ew(4, 6);
    ew(5, 7);
    ew(6, 4);
    cmp_rd();
    axw(`SDR_REG_CONFIG, 32'h0000_001e, `SDR_RESP_OKAY);
    go();
    cm(c_rd, 12'hff, 2'h0);
    nops(2);
    cm(c_bst, 12'h0, 2'h0);
    nops(12);
    ew(3, 255);
    ew(4, 0);
    ew(5, 1);
    cmp_rd();
    // latency 3, single word bursts
    axw(`SDR_REG_CONFIG, 32'h0000_0003, `SDR_RESP_OKAY);
    go();
    cm(c_rd, 12'h6, 2'h0);
    nops(12);
    ew(4, 6);
    cmp_rd();
    // latency 2, single word bursts
    axw(`SDR_REG_CONFIG, 32'h0000_0002, `SDR_RESP_OKAY);
    go();
    cm(c_rd, 12'h3, 2'h0);
    nops(12);
    ew(3, 3);
    cmp_rd();
    u_sdr_ctl_model.cmd(c_pre, seed[1:0], 12'h400, 16'h0, 2'h0);
    nops(3);
    axr(`SDR_REG_STATUS, 32'h0, `SDR_RESP_OKAY);
    u_sdr_ctl_model.cmd(c_ref, seed[3:2], seed[27:16], 16'h0, 2'h0);
    nops(3);
    u_sdr_ctl_model.cmd(c_ref, seed[5:4], seed[31:20], 16'h0, 2'h0);
    nops(3);
    axr(`SDR_REG_REFCNT, 32'h2, `SDR_RESP_OKAY);
    u_sdr_ctl_model.sr_enter();
    u_sdr_ctl_model.cmd(c_wr - 4'h1, 2'h2, 12'h1, 16'h0, 2'h0);
    axr(`SDR_REG_STATUS, 32'h0000_0010, `SDR_RESP_OKAY);
    nops(26);
    u_sdr_ctl_model.sr_exit();
    u_sdr_ctl_model.cmd(c_ref, 2'h0, 12'h0, 16'h0, 2'h0);
    nops(1);
    axr(`SDR_REG_SRCNT, 32'h3, `SDR_RESP_OKAY);
    axr(`SDR_REG_REFCNT, 32'h6, `SDR_RESP_OKAY);
    // clock enable low: a refresh must leave no trace
    clk_en <= 1'b0;
    cm(c_ref, 12'h0, 2'h0);
    nops(2);
    clk_en <= 1'b1;
    axr(`SDR_REG_REFCNT, 32'h6, `SDR_RESP_OKAY);
    axr(`SDR_REG_STATUS, 32'h0, `SDR_RESP_OKAY);
    end_sim();
  end
endmodule // sdr_core_tb
`default_nettype wire
